// ### inc/cbb_pkg.sv
package cbb_pkg;
  // Stream geometry
  localparam int CBB_DATA_W = 256;
  localparam int CBB_WORD_W = 32;
  localparam int CBB_MADDR_W = 20;
  // Header field positions (dword 0 at bits 31:0)
  localparam int CBB_FMT_HI = 31;
  localparam int CBB_FMT_LO = 29;
  localparam int CBB_TYPE_HI = 28;
  localparam int CBB_TYPE_LO = 24;
  localparam int CBB_LEN_HI = 9;
  localparam int CBB_LEN_LO = 0;
  localparam int CBB_REQID_LO = 48;
  localparam int CBB_TAG_LO = 40;
  localparam int CBB_FBE_LO = 32;
  localparam int CBB_CFGFN_LO = 80;
  localparam int CBB_CFGREG_LO = 66;
  localparam int CBB_ADDR_LO = 66;
  localparam int CBB_D3_LO = 96;
  localparam int CBB_D4_LO = 128;
  localparam int CBB_FUNC_BIT = 20;
  // Request type codes
  localparam logic [4:0] CBB_TYPE_MEM = 5'h00;
  localparam logic [4:0] CBB_TYPE_CFG0 = 5'h04;
  localparam logic [4:0] CBB_TYPE_MSG_HI = 5'h10;
  localparam logic [2:0] CBB_FMT_3DW_ND = 3'h0;
  localparam logic [2:0] CBB_FMT_4DW_ND = 3'h1;
  localparam logic [2:0] CBB_FMT_3DW_D = 3'h2;
  localparam logic [2:0] CBB_FMT_4DW_D = 3'h3;
  localparam logic [9:0] CBB_ONE_DW = 10'h001;
  // Completion status
  localparam logic [2:0] CBB_CPL_SC = 3'h0;
  localparam logic [2:0] CBB_CPL_UR = 3'h1;
  localparam logic [2:0] CBB_CPL_CA = 3'h4;
  localparam logic [2:0] CBB_CPL_FMT_D = 3'h2;
  localparam logic [2:0] CBB_CPL_FMT_ND = 3'h0;
  localparam logic [4:0] CBB_CPL_TYPE = 5'h0a;
  localparam logic [11:0] CBB_BYTES_DW = 12'h004;
  typedef enum logic [1:0] {
    CBB_K_CFGRD, CBB_K_CFGWR, CBB_K_MEMRD, CBB_K_MEMWR
  } cbb_kind_t;
endpackage : cbb_pkg

// ### src/cbb_bridge.sv
`timescale 1ns/1ps
module cbb_bridge
  import cbb_pkg::*;
#(
  parameter int DATA_W = CBB_DATA_W // Stream width
) (
  input wire logic clock_in,                      // 40 MHz clock
  input wire logic rst_in,                        // Sync reset, high
  input wire logic clk_en_in,                     // Freezes state when low
  output logic rx_accept_ready_out,               // Ready for a request
  input wire logic rx_packet_first_in,            // Start of packet
  input wire logic rx_packet_last_in,             // End of packet
  input wire logic rx_beat_valid_in,              // Beat valid
  input wire logic [DATA_W-1:0] rx_beat_payload_in, // Request beat
  input wire logic tx_ready_in,                   // Transmit may proceed
  output logic tx_packet_first_out,               // Completion start
  output logic tx_packet_last_out,                // Completion end
  output logic tx_beat_valid_out,                 // Completion valid
  output logic [DATA_W-1:0] tx_beat_payload_out,  // Completion beat
  output logic [31:0] cfg_address_out,            // Config register address
  output logic cfg_read_enable_out,               // Config read
  output logic cfg_write_enable_out,              // Config write
  output logic [31:0] cfg_write_word_out,         // Config write value
  output logic [3:0] cfg_byte_enable_out,         // Config byte enables
  output logic cfg_resp_request_out,              // Ask for write status
  input wire logic cfg_read_word_valid_in,        // Config read answer
  input wire logic [31:0] cfg_read_word_in,       // Config read value
  input wire logic cfg_resp_valid_in,             // Write status valid
  input wire logic [2:0] cfg_resp_status_in,      // Write status
  output logic [CBB_MADDR_W-1:0] memmaster_address_out, // Byte address
  output logic second_function_select_out,        // Selects function 1
  output logic memmaster_write_strobe_out,        // Memory write
  output logic [31:0] memmaster_write_word_out,   // Memory write word
  output logic [3:0] memmaster_byte_enable_out,   // Memory byte enables
  output logic memmaster_read_strobe_out,         // Memory read
  input wire logic memmaster_read_word_valid_in,  // Memory read answer
  input wire logic [31:0] memmaster_read_word_in  // Memory read word
);
  // ==========================================================
  // Decode helpers
  // ==========================================================
  function automatic logic has_data(input logic [2:0] fmt);
    return fmt == CBB_FMT_3DW_D || fmt == CBB_FMT_4DW_D;
  endfunction : has_data

  function automatic logic is_msg(input logic [4:0] typ);
    return typ[4:3] == CBB_TYPE_MSG_HI[4:3];
  endfunction : is_msg

  typedef enum logic [2:0] {
    CBB_IDLE, CBB_HEAD, CBB_ACCESS, CBB_WAIT_FALL, CBB_SEND
  } cbb_state_t;

  cbb_state_t state_reg;
  cbb_kind_t kind_reg;
  logic [DATA_W-1:0] head_reg;
  logic bad_reg;
  logic [2:0] status_reg;
  logic [31:0] word_reg;
  logic answered_reg;
  logic [DATA_W-1:0] cpl_beat;

  logic [2:0] h_fmt;
  logic [4:0] h_type;
  logic [9:0] h_len;
  logic h_4dw;
  logic [31:0] h_addr;
  logic [31:0] h_wdata;
  assign h_fmt = head_reg[CBB_FMT_HI:CBB_FMT_LO];
  assign h_type = head_reg[CBB_TYPE_HI:CBB_TYPE_LO];
  assign h_len = head_reg[CBB_LEN_HI:CBB_LEN_LO];
  assign h_4dw = h_fmt[0];
  // Low address dword sits one dword later in a four dword header
  assign h_addr = h_4dw ? head_reg[CBB_D3_LO +: CBB_WORD_W]
                        : head_reg[CBB_D3_LO - CBB_WORD_W +: CBB_WORD_W];
  assign h_wdata = h_4dw ? head_reg[CBB_D4_LO +: CBB_WORD_W]
                         : head_reg[CBB_D3_LO +: CBB_WORD_W];

  cbb_cpl_build u_cpl (
    .req_id_in(head_reg[CBB_REQID_LO +: 16]),
    .tag_in(head_reg[CBB_TAG_LO +: 8]),
    .status_in(status_reg),
    .with_data_in(kind_reg == CBB_K_CFGRD || kind_reg == CBB_K_MEMRD),
    .word_in(word_reg),
    .beat_out(cpl_beat)
  );

  // ==========================================================
  // Request sequencer
  // ==========================================================
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_reg <= CBB_IDLE;
      kind_reg <= CBB_K_CFGRD;
      head_reg <= '0;
      bad_reg <= 1'b0;
      answered_reg <= 1'b0;
    end else if (clk_en_in) begin
      case (state_reg)
        CBB_IDLE: begin
          answered_reg <= 1'b0;
          if (rx_accept_ready_out && rx_beat_valid_in &&
              rx_packet_first_in) begin
            head_reg <= rx_beat_payload_in;
            state_reg <= CBB_HEAD;
          end
        end
        CBB_HEAD: begin
          // Commands go out only once the first-beat flag has fallen
          if (!rx_packet_first_in) begin
            state_reg <= CBB_ACCESS;
            if (h_type == CBB_TYPE_CFG0) begin
              kind_reg <= has_data(h_fmt) ? CBB_K_CFGWR : CBB_K_CFGRD;
              bad_reg <= h_len != CBB_ONE_DW ||
                         h_fmt == CBB_FMT_4DW_ND ||
                         h_fmt == CBB_FMT_4DW_D ||
                         head_reg[CBB_CFGFN_LO + 3 +: 5] != 5'h00;
            end else if (h_type == CBB_TYPE_MEM) begin
              kind_reg <= has_data(h_fmt) ? CBB_K_MEMWR : CBB_K_MEMRD;
              bad_reg <= h_len != CBB_ONE_DW;
              if (has_data(h_fmt) && h_len != CBB_ONE_DW)
                state_reg <= CBB_IDLE;
            end else begin
              // Messages and any other request are dropped
              state_reg <= CBB_IDLE;
            end
          end
        end
        CBB_ACCESS: begin
          if (bad_reg || kind_reg == CBB_K_MEMWR)
            state_reg <= kind_reg == CBB_K_MEMWR ? CBB_IDLE : CBB_SEND;
          else
            state_reg <= CBB_WAIT_FALL;
        end
        CBB_WAIT_FALL: begin
          // Answer is taken when its valid falls after having been seen
          if (cfg_read_word_valid_in || cfg_resp_valid_in ||
              memmaster_read_word_valid_in)
            answered_reg <= 1'b1;
          else if (answered_reg)
            state_reg <= CBB_SEND;
        end
        CBB_SEND: begin
          if (tx_beat_valid_out && tx_ready_in)
            state_reg <= CBB_IDLE;
        end
        default: state_reg <= CBB_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Captured answer word and status
  // ==========================================================
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      word_reg <= '0;
      status_reg <= CBB_CPL_SC;
    end else if (clk_en_in) begin
      if (state_reg == CBB_ACCESS) begin
        word_reg <= '0;
        if (bad_reg)
          status_reg <= kind_reg == CBB_K_MEMRD ? CBB_CPL_CA
                                                : CBB_CPL_UR;
        else
          status_reg <= CBB_CPL_SC;
      end else if (state_reg == CBB_WAIT_FALL) begin
        if (cfg_read_word_valid_in)
          word_reg <= cfg_read_word_in;
        if (memmaster_read_word_valid_in)
          word_reg <= memmaster_read_word_in;
        if (cfg_resp_valid_in)
          status_reg <= cfg_resp_status_in;
      end
    end
  end

  // ==========================================================
  // Configuration and memory side outputs
  // ==========================================================
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cfg_address_out <= '0;
      cfg_read_enable_out <= 1'b0;
      cfg_write_enable_out <= 1'b0;
      cfg_write_word_out <= '0;
      cfg_byte_enable_out <= '0;
      cfg_resp_request_out <= 1'b0;
      memmaster_address_out <= '0;
      second_function_select_out <= 1'b0;
      memmaster_write_strobe_out <= 1'b0;
      memmaster_write_word_out <= '0;
      memmaster_byte_enable_out <= '0;
      memmaster_read_strobe_out <= 1'b0;
    end else if (clk_en_in) begin
      cfg_read_enable_out <= 1'b0;
      cfg_write_enable_out <= 1'b0;
      cfg_resp_request_out <= 1'b0;
      memmaster_write_strobe_out <= 1'b0;
      memmaster_read_strobe_out <= 1'b0;
      if (state_reg == CBB_ACCESS && !bad_reg) begin
        case (kind_reg)
          CBB_K_CFGRD: begin
            cfg_read_enable_out <= 1'b1;
            cfg_address_out <= {head_reg[CBB_CFGFN_LO +: 8], 12'h000,
                                head_reg[CBB_CFGREG_LO +: 10], 2'b00};
            cfg_byte_enable_out <= head_reg[CBB_FBE_LO +: 4];
          end
          CBB_K_CFGWR: begin
            cfg_write_enable_out <= 1'b1;
            cfg_resp_request_out <= 1'b1;
            cfg_address_out <= {head_reg[CBB_CFGFN_LO +: 8], 12'h000,
                                head_reg[CBB_CFGREG_LO +: 10], 2'b00};
            cfg_write_word_out <= head_reg[CBB_D3_LO +: 32];
            cfg_byte_enable_out <= head_reg[CBB_FBE_LO +: 4];
          end
          CBB_K_MEMRD, CBB_K_MEMWR: begin
            memmaster_address_out <= h_addr[CBB_MADDR_W-1:0];
            second_function_select_out <=
              h_addr[CBB_FUNC_BIT];
            memmaster_byte_enable_out <= head_reg[CBB_FBE_LO +: 4];
            if (kind_reg == CBB_K_MEMWR) begin
              memmaster_write_strobe_out <= 1'b1;
              memmaster_write_word_out <= h_wdata;
            end else begin
              memmaster_read_strobe_out <= 1'b1;
            end
          end
          default: cfg_read_enable_out <= 1'b0;
        endcase
      end
    end
  end

  // ==========================================================
  // Receive ready and transmit
  // ==========================================================
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rx_accept_ready_out <= 1'b0;
      tx_packet_first_out <= 1'b0;
      tx_packet_last_out <= 1'b0;
      tx_beat_valid_out <= 1'b0;
      tx_beat_payload_out <= '0;
    end else if (clk_en_in) begin
      // Ready only while idle: one request in flight, no buffering
      rx_accept_ready_out <= state_reg == CBB_IDLE &&
                             !(rx_accept_ready_out && rx_beat_valid_in &&
                               rx_packet_first_in);
      if (state_reg == CBB_SEND && !tx_beat_valid_out) begin
        tx_packet_first_out <= 1'b1;
        tx_packet_last_out <= 1'b1;
        tx_beat_valid_out <= 1'b1;
        tx_beat_payload_out <= cpl_beat;
      end else if (tx_beat_valid_out && tx_ready_in) begin
        tx_packet_first_out <= 1'b0;
        tx_packet_last_out <= 1'b0;
        tx_beat_valid_out <= 1'b0;
      end
    end
  end
endmodule : cbb_bridge

// ### src/cbb_cpl_build.sv
`timescale 1ns/1ps
// Combinational completion header and payload builder.
module cbb_cpl_build
  import cbb_pkg::*;
(
  input wire logic [15:0] req_id_in,    // Requester id
  input wire logic [7:0] tag_in,        // Request tag
  input wire logic [2:0] status_in,     // Completion status
  input wire logic with_data_in,        // Completion carries a word
  input wire logic [31:0] word_in,      // Returned word
  output logic [CBB_DATA_W-1:0] beat_out // Completion beat
);
  always_comb begin
    beat_out = '0;
    beat_out[CBB_FMT_HI:CBB_FMT_LO] = with_data_in ? CBB_CPL_FMT_D
                                                  : CBB_CPL_FMT_ND;
    beat_out[CBB_TYPE_HI:CBB_TYPE_LO] = CBB_CPL_TYPE;
    beat_out[CBB_LEN_HI:CBB_LEN_LO] = with_data_in ? CBB_ONE_DW : 10'h000;
    beat_out[47:45] = status_in;
    beat_out[43:32] = CBB_BYTES_DW;
    beat_out[95:80] = req_id_in;
    beat_out[79:72] = tag_in;
    beat_out[CBB_D3_LO +: CBB_WORD_W] = word_in;
  end
endmodule : cbb_cpl_build

// ### testbench/cbb_checker.sv
`timescale 1ns/1ps
module cbb_checker
  import cbb_pkg::*;
#(
  parameter int DATA_W = CBB_DATA_W // Stream width
) (
  input wire logic clock_in, // Clock
  input wire logic rst_in, // Reset
  input wire logic rx_accept_ready_out, // Ready
  input wire logic rx_packet_first_in, // Rx first
  input wire logic rx_beat_valid_in, // Rx valid
  input wire logic tx_ready_in, // Tx ready
  input wire logic tx_packet_first_out, // Tx first
  input wire logic tx_packet_last_out, // Tx last
  input wire logic tx_beat_valid_out, // Tx valid
  input wire logic [DATA_W-1:0] tx_beat_payload_out, // Tx beat
  input wire logic cfg_read_enable_out, // Cfg read
  input wire logic cfg_write_enable_out, // Cfg write
  input wire logic cfg_resp_request_out, // Status request
  input wire logic cfg_read_word_valid_in, // Cfg answer
  input wire logic cfg_resp_valid_in, // Status valid
  input wire logic memmaster_write_strobe_out, // Mem write
  input wire logic memmaster_read_strobe_out, // Mem read
  input wire logic memmaster_read_word_valid_in // Mem answer
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // =====================================================
  // Assertions
  a_ready_drops: assert property (rx_accept_ready_out && rx_beat_valid_in &&
    rx_packet_first_in |=> !rx_accept_ready_out)
    else $error("ready held after take");
  a_cfgrd_after: assert property (cfg_read_enable_out |->
    !rx_accept_ready_out && !$past(rx_packet_first_in))
    else $error("config read out of place");
  a_cfgwr_resp: assert property (cfg_write_enable_out |->
    cfg_resp_request_out)
    else $error("write without status request");
  a_rdcpl_delay: assert property ($fell(cfg_read_word_valid_in) |->
    ##[1:4] tx_beat_valid_out)
    else $error("no config read completion");
  a_wrcpl_delay: assert property ($fell(cfg_resp_valid_in) |->
    ##[1:4] tx_beat_valid_out)
    else $error("no config write completion");
  a_memrd_cpl: assert property ($fell(memmaster_read_word_valid_in) |->
    ##[1:4] tx_beat_valid_out)
    else $error("no memory read completion");
  a_tx_framing: assert property (tx_beat_valid_out |->
    tx_packet_first_out && tx_packet_last_out)
    else $error("completion not single beat");
  a_tx_holds: assert property (tx_beat_valid_out && !tx_ready_in |=>
    tx_beat_valid_out && $stable(tx_beat_payload_out))
    else $error("completion dropped while stalled");
  a_wr_nocpl: assert property (memmaster_write_strobe_out |=>
    (!tx_beat_valid_out) [*4])
    else $error("memory write got completion");
  a_rd_pulse: assert property (memmaster_read_strobe_out |=>
    !memmaster_read_strobe_out)
    else $error("read strobe not a pulse");
  c_cfg_read: cover property (cfg_read_enable_out);
  c_cfg_write: cover property (cfg_write_enable_out);
  c_mem_read: cover property (memmaster_read_strobe_out);
  c_mem_write: cover property (memmaster_write_strobe_out);
endmodule : cbb_checker

// ### testbench/cbb_partner.sv
`timescale 1ns/1ps
// Both function slaves: config port and one word per function
module cbb_partner #(
  parameter logic [31:0] CFG_WORD = 32'h5a3c96e1 // Arbitrary config value
) (
  input wire logic clock_in, // Clock
  input wire logic rst_in, // Reset
  input wire logic cfg_rd_in, // Config read
  input wire logic cfg_rq_in, // Status request
  input wire logic mem_wr_in, // Memory write
  input wire logic [31:0] mem_wword_in, // Write word
  input wire logic sel_in, // Second function
  input wire logic mem_rd_in, // Memory read
  output logic cfg_vld_out, // Config answer
  output logic [31:0] cfg_word_out, // Config word
  output logic resp_vld_out, // Status valid
  output logic mem_vld_out, // Memory answer
  output logic [31:0] mem_word_out // Memory word
);
  logic [31:0] fn_reg [2];
  logic [31:0] hold_reg;
  always_ff @(posedge clock_in) begin
    cfg_vld_out <= cfg_rd_in && !rst_in;
    resp_vld_out <= cfg_rq_in && !rst_in;
    mem_vld_out <= mem_rd_in && !rst_in;
    if (mem_rd_in) hold_reg <= fn_reg[sel_in];
    if (rst_in) fn_reg <= '{32'h0, 32'h0};
    else if (mem_wr_in) fn_reg[sel_in] <= mem_wword_in;
  end
  // Released buses show the inverse so stale words never pass
  assign cfg_word_out = cfg_vld_out ? CFG_WORD : ~CFG_WORD;
  assign mem_word_out = mem_vld_out ? hold_reg : ~hold_reg;
endmodule : cbb_partner

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import cbb_pkg::*;
  localparam logic [31:0] CW = 32'h5a3c96e1;
  logic clock_in = 0, rst_in = 1, clk_en_in = 1, rx_accept_ready_out;
  logic rx_packet_first_in = 0, rx_packet_last_in = 0, rx_beat_valid_in = 0;
  logic [255:0] rx_beat_payload_in = '0, tx_beat_payload_out, p;
  logic tx_ready_in = 1, tx_packet_first_out, tx_packet_last_out;
  logic tx_beat_valid_out, cfg_read_enable_out, cfg_write_enable_out;
  logic [31:0] cfg_address_out, cfg_write_word_out, cfg_read_word_in;
  logic [31:0] memmaster_write_word_out, memmaster_read_word_in;
  logic [31:0] rd_addr, wr_word;
  logic [24:0] ma_seen;
  logic [3:0] cbe_seen;
  logic [3:0] cfg_byte_enable_out, memmaster_byte_enable_out;
  logic cfg_resp_request_out, cfg_read_word_valid_in, cfg_resp_valid_in;
  logic [2:0] cfg_resp_status_in = CBB_CPL_SC;
  logic [19:0] memmaster_address_out;
  logic second_function_select_out, memmaster_write_strobe_out;
  logic memmaster_read_strobe_out, memmaster_read_word_valid_in;
  int errors = 0, cmp_count = 0;
  cbb_bridge dut (.*);
  cbb_partner #(.CFG_WORD(CW)) far (.clock_in, .rst_in,
    .cfg_rd_in(cfg_read_enable_out), .cfg_rq_in(cfg_resp_request_out),
    .mem_wr_in(memmaster_write_strobe_out),
    .mem_wword_in(memmaster_write_word_out),
    .sel_in(second_function_select_out),
    .mem_rd_in(memmaster_read_strobe_out),
    .cfg_vld_out(cfg_read_word_valid_in), .cfg_word_out(cfg_read_word_in),
    .resp_vld_out(cfg_resp_valid_in),
    .mem_vld_out(memmaster_read_word_valid_in),
    .mem_word_out(memmaster_read_word_in));
  always #12.5 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    if (cfg_read_enable_out) begin
      rd_addr <= cfg_address_out;
      cbe_seen <= cfg_byte_enable_out;
    end
    if (cfg_write_enable_out) wr_word <= cfg_write_word_out;
    if (memmaster_write_strobe_out || memmaster_read_strobe_out)
      ma_seen <= {memmaster_byte_enable_out, second_function_select_out,
                  memmaster_address_out};
  end
  // =====================================================
  // Shared tasks
  task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %h seen %h", n, exp, seen);
    end
  endtask : check
  function automatic logic [255:0] hdr(logic [7:0] ft, logic [9:0] len,
    logic [31:0] dw2, logic [31:0] dw3);
    return {128'h0, dw3, dw2, 32'h01002a0f, ft, 14'h0, len};
  endfunction : hdr
  task automatic send(logic [255:0] h);
    int n = 0;
    do @(posedge clock_in) #1; while (!rx_accept_ready_out && ++n < 50);
    check("rx_ready", rx_accept_ready_out, 1);
    {rx_packet_first_in, rx_packet_last_in, rx_beat_valid_in} = 3'h7;
    rx_beat_payload_in = h;
    @(posedge clock_in);
    #1 {rx_packet_first_in, rx_packet_last_in, rx_beat_valid_in} = 3'h0;
  endtask : send
  task automatic cpl(logic [2:0] fmt, logic [2:0] st, logic [31:0] d);
    int n = 0;
    while (!tx_beat_valid_out && n++ < 40) @(posedge clock_in) #1;
    p = tx_beat_payload_out;
    check("tx_first", tx_packet_first_out, 1);
    check("tx_last", tx_packet_last_out, 1);
    check("cpl_fmt", p[31:29], fmt);
    check("cpl_type", p[28:24], CBB_CPL_TYPE);
    check("cpl_status", p[47:45], st);
    check("cpl_tag", p[79:72], 8'h2a);
    check("cpl_reqid", p[95:80], 16'h0100);
    if (fmt == CBB_CPL_FMT_D) check("cpl_word", p[127:96], d);
    @(posedge clock_in) #1;
  endtask : cpl
  task automatic none();
    int seen = 0;
    repeat (20) @(posedge clock_in) #1 seen += tx_beat_valid_out;
    check("silent", seen, 0);
  endtask : none
  // =====================================================
  // Scenarios
  task automatic t_cfg();
    tx_ready_in = 0;
    send(hdr({CBB_FMT_3DW_ND, CBB_TYPE_CFG0}, 1, 32'h00010010, 0));
    repeat (12) @(posedge clock_in);
    #1 check("stall_valid", tx_beat_valid_out, 1);
    clk_en_in = 0;
    tx_ready_in = 1;
    repeat (4) @(posedge clock_in);
    #1 check("frozen_valid", tx_beat_valid_out, 1);
    clk_en_in = 1;
    check("cfg_addr", rd_addr, 32'h01000010);
    check("cfg_be", cbe_seen, 4'hf);
    cpl(CBB_CPL_FMT_D, CBB_CPL_SC, CW);
    send(hdr({CBB_FMT_3DW_D, CBB_TYPE_CFG0}, 1, 32'h00010004, 32'h60));
    cpl(CBB_CPL_FMT_ND, CBB_CPL_SC, 0);
    check("cfg_wword", wr_word, 32'h60);
  endtask : t_cfg
  task automatic t_mem();
    logic [7:0] wr = {CBB_FMT_3DW_D, CBB_TYPE_MEM};
    logic [7:0] rd = {CBB_FMT_3DW_ND, CBB_TYPE_MEM};
    send(hdr(wr, 1, 32'h00100008, 32'hbabeface));
    none();
    check("mem_access", ma_seen, {4'hf, 1'b1, 20'h00008});
    send(hdr(wr, 1, 32'h00000000, 32'h1234abcd));
    none();
    check("mem_access", ma_seen, {4'hf, 1'b0, 20'h00000});
    send(hdr(wr, 2, 32'h00100000, 32'h0badf00d));
    none();
    send(hdr({CBB_FMT_3DW_D, CBB_TYPE_MSG_HI}, 1, 0, 32'h0badf00d));
    none();
    send(hdr(rd, 1, 32'h00100000, 0));
    cpl(CBB_CPL_FMT_D, CBB_CPL_SC, 32'hbabeface);
    send(hdr(rd, 1, 32'h00000000, 0));
    cpl(CBB_CPL_FMT_D, CBB_CPL_SC, 32'h1234abcd);
    send(hdr(rd, 2, 32'h00000000, 0));
    cpl(CBB_CPL_FMT_D, CBB_CPL_CA, 0);
    send(hdr({CBB_FMT_3DW_ND, CBB_TYPE_CFG0}, 1, 32'h00080010, 0));
    cpl(CBB_CPL_FMT_D, CBB_CPL_UR, 0);
  endtask : t_mem
  task automatic test_done();
    $display("checks %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  initial begin
    repeat (10) @(posedge clock_in);
    #1 rst_in = 0;
    t_cfg();
    t_mem();
    test_done();
  end
  initial begin
    #(25 * 4000);
    errors++;
    test_done();
  end
endmodule : tb_top
bind cbb_bridge cbb_checker #(.DATA_W(DATA_W)) chk (.*);
